/* File: dsoc_pkg.sv */
// shared constants and types of the deserializer output state control
package dsoc_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_OVERRIDE = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [7:0] OVERRIDE_ON = 8'h01;
  localparam logic [7:0] OVERRIDE_RST = 8'h00;
  // config field layout (matches dsoc_cfg_s)
  localparam int CFG_W = 10;
  localparam logic [9:0] CFG_RST = 10'h0;
  // control register: hold set/reset bit
  localparam int CTL_HOLD_BIT = 0;
  // status bit positions
  localparam int ST_LOCK = 0;
  localparam int ST_PRESENT = 1;
  localparam int ST_STRAP_DONE = 2;
  localparam int ST_HOLD = 3;
  localparam int ST_OSC_SRC = 4;
  // strap positions on the video pad vector
  localparam int STRAP_IDLE = 0;
  localparam int STRAP_OSC_LO = 1;
  localparam int STRAP_EDGE = 4;
  localparam int STRAP_FILT = 5;
  localparam int STRAP_MAP_LO = 6;
  localparam int STRAP_LF = 8;
  // pad widths
  localparam int RGB_W = 24;
  localparam int VID_W = 27;
  // fallback oscillator: system clock and half periods per select code
  localparam int SYS_CLK_MHZ = 100;
  localparam logic [3:0] OSC_HALF_50M = 4'h1;
  localparam logic [3:0] OSC_HALF_25M = 4'h2;
  localparam logic [3:0] OSC_HALF_16M7 = 4'h3;
  localparam logic [3:0] OSC_HALF_12M5 = 4'h4;
  localparam logic [3:0] OSC_HALF_10M = 4'h5;
  localparam logic [3:0] OSC_HALF_8M3 = 4'h6;
  localparam logic [3:0] OSC_HALF_6M3 = 4'h8;
  localparam logic [2:0] OSC_OFF = 3'h0;

  typedef struct packed {
    logic hold_en;
    logic low_freq_optimization;
    logic [1:0] map_sel;
    logic filt_en;
    logic edge_pol;
    logic [2:0] fallback_osc_freq_select;
    logic idle_sel;
  } dsoc_cfg_s;

  typedef struct packed {
    logic [RGB_W-1:0] rgb;
    logic vs;
    logic hs;
    logic de;
  } dsoc_vid_s;

  typedef enum {OUT_OFF, OUT_IDLE_LOW, OUT_IDLE_FLOAT, OUT_OSC, OUT_HOLD, OUT_ACTIVE} dsoc_mode_e;
endpackage

/* File: dsoc_out_ctrl.sv */
// deserializer output state control: lock flag, pixel bus state, straps, registers
`timescale 1ns/1ns
`default_nettype none
module dsoc_out_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link status and recovered stream
  input wire logic i_pdb,
  input wire logic i_embedded_clk_present,
  input wire logic i_cdr_locked,
  input wire logic i_rec_pclk,
  input wire dsoc_pkg::dsoc_vid_s i_vid,
  // pads: video bus, pass, pixel clock, lock
  input wire logic [dsoc_pkg::VID_W-1:0] i_vid_pad,
  input wire logic i_pass_pad,
  output logic [dsoc_pkg::VID_W-1:0] o_vid_pad,
  output logic [dsoc_pkg::VID_W-1:0] o_vid_pad_oe,
  output logic o_pass,
  output logic o_pass_oe,
  output logic o_pclk,
  output logic o_pclk_oe,
  output logic o_lock,
  output logic o_lock_oe,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  // input synchronisers
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [dsoc_pkg::VID_W:0] pad1;
  logic [dsoc_pkg::VID_W:0] pad2;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= 5'h0;
      sync2 <= 5'h0;
      pad1 <= '0;
      pad2 <= '0;
    end else begin
      sync1 <= {i_pdb, i_embedded_clk_present, i_cdr_locked, i_rec_pclk, 1'b0};
      sync2 <= sync1;
      pad1 <= {i_pass_pad, i_vid_pad};
      pad2 <= pad1;
    end
  end
  wire power_down_bar_input = sync2[4];
  wire present = sync2[3];
  wire rec_pclk = sync2[1];
  wire locked = power_down_bar_input & present & sync2[2];

  // strap capture on first power-up
  logic pdb_q;
  logic strap_done;
  dsoc_pkg::dsoc_cfg_s strap;
  wire pdb_rise = power_down_bar_input & ~pdb_q;
  // undriven pads resolve low through the pad pulldown
  wire [dsoc_pkg::VID_W-1:0] spad = pad2[dsoc_pkg::VID_W-1:0];
  wire dsoc_pkg::dsoc_cfg_s strap_in = '{
    hold_en: pad2[dsoc_pkg::VID_W],
    low_freq_optimization: spad[dsoc_pkg::STRAP_LF],
    map_sel: spad[dsoc_pkg::STRAP_MAP_LO +: 2],
    filt_en: spad[dsoc_pkg::STRAP_FILT],
    edge_pol: spad[dsoc_pkg::STRAP_EDGE],
    fallback_osc_freq_select: spad[dsoc_pkg::STRAP_OSC_LO +: 3],
    idle_sel: spad[dsoc_pkg::STRAP_IDLE]
  };
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pdb_q <= 1'b0;
      strap_done <= 1'b0;
      strap <= dsoc_pkg::CFG_RST;
    end else begin
      pdb_q <= power_down_bar_input;
      if (pdb_rise && !strap_done) begin
        strap_done <= 1'b1;
        strap <= strap_in;
      end
    end
  end

  // registers
  logic [7:0] ovr;
  logic [dsoc_pkg::CFG_W-1:0] cfg_reg;
  logic hold_ctl;
  logic hold_active;
  logic osc_src;
  wire acc = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
  wire wr = i_avs_write & ~o_avs_waitrequest;
  wire hit_ovr = (i_avs_address == dsoc_pkg::ADDR_OVERRIDE);
  wire hit_cfg = (i_avs_address == dsoc_pkg::ADDR_CONFIG);
  wire hit_ctl = (i_avs_address == dsoc_pkg::ADDR_CONTROL);
  wire hit_st = (i_avs_address == dsoc_pkg::ADDR_STATUS);
  wire [4:0] status = {osc_src, hold_active, strap_done, present, locked};
  wire [31:0] rd_mux =
    hit_ovr ? {24'h000000, ovr} :
    hit_cfg ? {22'h0, cfg_reg} :
    hit_ctl ? {31'h0, hold_ctl} :
    hit_st ? {27'h0, status} : 32'h00000000;
  wire next_hold_ctl = (wr && hit_ctl) ? i_avs_writedata[dsoc_pkg::CTL_HOLD_BIT] : hold_ctl;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovr <= dsoc_pkg::OVERRIDE_RST;
      cfg_reg <= dsoc_pkg::CFG_RST;
      hold_ctl <= 1'b0;
    end else if (!power_down_bar_input) begin
      ovr <= dsoc_pkg::OVERRIDE_RST;
      cfg_reg <= dsoc_pkg::CFG_RST;
      hold_ctl <= 1'b0;
    end else if (wr) begin
      if (hit_ovr) begin
        ovr <= i_avs_writedata[7:0];
      end else if (hit_cfg) begin
        cfg_reg <= i_avs_writedata[dsoc_pkg::CFG_W-1:0];
      end else if (hit_ctl) begin
        hold_ctl <= next_hold_ctl;
      end
    end
  end

  // configuration source
  wire use_reg = (ovr == dsoc_pkg::OVERRIDE_ON);
  wire dsoc_pkg::dsoc_cfg_s cfg = use_reg ? dsoc_pkg::dsoc_cfg_s'(cfg_reg) : strap;

  // hold-outputs-low state
  logic lock_q;
  wire lock_fall = lock_q & ~locked;
  wire ctl_write = wr & hit_ctl & acc;
  wire release_req = ctl_write & ~hold_ctl & next_hold_ctl & locked;
  wire manual_set = ctl_write & hold_ctl & ~next_hold_ctl & locked;
  // stays armed while the feature is off, so enabling it forces the hold
  wire next_hold = ~cfg.hold_en |
    (lock_fall | ~locked | manual_set | (hold_active & ~release_req));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_q <= 1'b0;
      hold_active <= 1'b1;
    end else begin
      lock_q <= locked;
      hold_active <= next_hold;
    end
  end

  // output mode
  wire osc_on = (cfg.fallback_osc_freq_select != dsoc_pkg::OSC_OFF);
  dsoc_pkg::dsoc_mode_e mode;
  always_comb begin
    if (!power_down_bar_input || !strap_done) begin
      mode = dsoc_pkg::OUT_OFF;
    end else if (cfg.hold_en && hold_active) begin
      mode = dsoc_pkg::OUT_HOLD;
    end else if (locked) begin
      mode = dsoc_pkg::OUT_ACTIVE;
    end else if (!present && osc_on) begin
      mode = dsoc_pkg::OUT_OSC;
    end else if (cfg.idle_sel) begin
      mode = dsoc_pkg::OUT_IDLE_FLOAT;
    end else begin
      mode = dsoc_pkg::OUT_IDLE_LOW;
    end
  end

  // fallback oscillator
  function automatic logic [3:0] osc_half(input logic [2:0] sel);
    case (sel)
      3'h1: osc_half = dsoc_pkg::OSC_HALF_50M;
      3'h2: osc_half = dsoc_pkg::OSC_HALF_25M;
      3'h3: osc_half = dsoc_pkg::OSC_HALF_16M7;
      3'h4: osc_half = dsoc_pkg::OSC_HALF_12M5;
      3'h5: osc_half = dsoc_pkg::OSC_HALF_10M;
      3'h6: osc_half = dsoc_pkg::OSC_HALF_8M3;
      default: osc_half = dsoc_pkg::OSC_HALF_6M3;
    endcase
  endfunction
  logic [3:0] osc_cnt;
  logic internal_osc_clock;
  wire osc_wrap = (osc_cnt >= osc_half(cfg.fallback_osc_freq_select) - 4'h1);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_cnt <= 4'h0;
      internal_osc_clock <= 1'b0;
    end else if (!osc_on) begin
      osc_cnt <= 4'h0;
      internal_osc_clock <= 1'b0;
    end else if (osc_wrap) begin
      osc_cnt <= 4'h0;
      internal_osc_clock <= ~internal_osc_clock;
    end else begin
      osc_cnt <= osc_cnt + 4'h1;
    end
  end

  // glitch-free pixel clock source switch
  logic pclk_lvl;
  logic pclk_prev;
  wire want_osc = (mode == dsoc_pkg::OUT_OSC);
  wire new_lvl = want_osc ? internal_osc_clock : rec_pclk;
  // change source only once the new source sits at the held level
  wire may_switch = (want_osc != osc_src) & (new_lvl == pclk_lvl);
  wire next_src = may_switch ? want_osc : osc_src;
  wire src_lvl = next_src ? internal_osc_clock : rec_pclk;
  wire next_pclk_lvl = (want_osc != next_src) ? pclk_lvl : src_lvl;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_src <= 1'b0;
      pclk_lvl <= 1'b0;
      pclk_prev <= 1'b0;
    end else begin
      osc_src <= next_src;
      pclk_lvl <= next_pclk_lvl;
      pclk_prev <= pclk_lvl;
    end
  end
  wire launch = cfg.edge_pol ? (pclk_lvl & ~pclk_prev) : (~pclk_lvl & pclk_prev);

  // control filter and lsb map
  function automatic logic [2:0] filt3(input logic [2:0] din, input logic [2:0] h1,
                                       input logic [2:0] h2, input logic [2:0] cur);
    logic [2:0] agree;
    agree = ~(din ^ h1) & ~(h1 ^ h2);
    filt3 = (agree & din) | (~agree & cur);
  endfunction
  function automatic logic [7:0] lsb_map(input logic [7:0] c, input logic [1:0] sel);
    if (sel[1]) begin
      lsb_map = {c[7:2], 2'h0};
    end else if (sel[0]) begin
      lsb_map = {c[7:2], {2{c[7]}}};
    end else begin
      lsb_map = {c[7:2], c[5:4]};
    end
  endfunction
  logic [2:0] ctl_h1;
  logic [2:0] ctl_h2;
  logic [2:0] ctl_f;
  logic [dsoc_pkg::RGB_W-1:0] rgb_q;
  wire [2:0] ctl_in = {i_vid.vs, i_vid.hs, i_vid.de};
  // level must stand three pixel clocks to pass
  wire [2:0] ctl_next = cfg.filt_en ? filt3(ctl_in, ctl_h1, ctl_h2, ctl_f) : ctl_in;
  wire [dsoc_pkg::RGB_W-1:0] rgb_map = {lsb_map(i_vid.rgb[23:16], cfg.map_sel),
    lsb_map(i_vid.rgb[15:8], cfg.map_sel), lsb_map(i_vid.rgb[7:0], cfg.map_sel)};
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_h1 <= 3'h0;
      ctl_h2 <= 3'h0;
      ctl_f <= 3'h0;
      rgb_q <= '0;
    end else if (launch) begin
      ctl_h1 <= ctl_in;
      ctl_h2 <= ctl_h1;
      ctl_f <= ctl_next;
      rgb_q <= rgb_map;
    end
  end

  // pad drivers
  wire act = (mode == dsoc_pkg::OUT_ACTIVE);
  wire drv_vid = (mode != dsoc_pkg::OUT_OFF) & (mode != dsoc_pkg::OUT_IDLE_FLOAT);
  wire drv_pclk = act | want_osc;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_vid_pad <= '0;
      o_vid_pad_oe <= '0;
      o_pclk <= 1'b0;
      o_pclk_oe <= 1'b0;
      o_lock <= 1'b0;
      o_lock_oe <= 1'b0;
      o_pass <= 1'b0;
      o_pass_oe <= 1'b0;
    end else begin
      o_vid_pad <= act ? {ctl_f, rgb_q} : '0;
      o_vid_pad_oe <= {dsoc_pkg::VID_W{drv_vid}};
      o_pclk <= drv_pclk ? pclk_lvl : 1'b0;
      o_pclk_oe <= drv_vid;
      o_lock <= act | (locked & mode == dsoc_pkg::OUT_HOLD);
      o_lock_oe <= power_down_bar_input;
      o_pass <= act;
      o_pass_oe <= power_down_bar_input & strap_done;
    end
  end
endmodule
`default_nettype wire

/* File: dsoc_out_ctrl_monitor.sv */
// checker of lock, output state and bus handshake behaviour
`timescale 1ns/1ns
`default_nettype none
module dsoc_out_ctrl_monitor (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // observed pins
  input wire logic i_pdb,
  input wire logic i_embedded_clk_present,
  input wire logic i_cdr_locked,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [dsoc_pkg::VID_W-1:0] o_vid_pad,
  input wire logic [dsoc_pkg::VID_W-1:0] o_vid_pad_oe,
  input wire logic o_pass,
  input wire logic o_pass_oe,
  input wire logic o_pclk_oe,
  input wire logic o_lock,
  input wire logic o_lock_oe,
  input wire logic o_avs_waitrequest
);
  logic seen_pdb;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seen_pdb <= 1'b0;
    end else if (i_pdb) begin
      seen_pdb <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_off_all_float: assert property ((!i_pdb)[*4] |->
    !o_lock_oe && !o_pass_oe && !o_pclk_oe && o_vid_pad_oe == '0) else $error("driven in power down");
  a_pre_power_float: assert property (!seen_pdb |-> o_vid_pad_oe == '0 && !o_pclk_oe)
    else $error("pads driven before first power up");
  a_lock_driven: assert property (i_pdb[*5] |-> o_lock_oe)
    else $error("lock flag not driven");
  a_lock_lost_low: assert property ((!i_embedded_clk_present)[*4] |-> !(o_lock && o_lock_oe))
    else $error("lock high without embedded clock");
  a_lock_goes_high: assert property ((i_pdb && i_embedded_clk_present && i_cdr_locked)[*6]
    |-> o_lock && o_lock_oe) else $error("lock not high");
  a_pass_needs_lock: assert property (o_pass && o_pass_oe |-> o_lock)
    else $error("pass high while unlocked");
  a_quiet_unlocked: assert property (!o_lock && !$past(o_lock) |->
    (o_vid_pad & o_vid_pad_oe) == '0) else $error("video high while unlocked");
  a_wait_one_cycle: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_has_cause: assert property ($fell(o_avs_waitrequest) |->
    $past(i_avs_read) || $past(i_avs_write)) else $error("answer without request");
  c_lock_rise: cover property ($rose(o_lock));
  c_lock_fall: cover property ($fell(o_lock));
  c_bus_write: cover property ($fell(o_avs_waitrequest) && i_avs_write);
endmodule
bind dsoc_out_ctrl dsoc_out_ctrl_monitor u_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_pdb(i_pdb),
  .i_embedded_clk_present(i_embedded_clk_present), .i_cdr_locked(i_cdr_locked),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_vid_pad(o_vid_pad),
  .o_vid_pad_oe(o_vid_pad_oe), .o_pass(o_pass), .o_pass_oe(o_pass_oe), .o_pclk_oe(o_pclk_oe),
  .o_lock(o_lock), .o_lock_oe(o_lock_oe), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

/* File: dsoc_link_model.sv */
// upstream link model: embedded clock, lock sequence, recovered clock and data
`timescale 1ns/1ns
`default_nettype none
module dsoc_link_model (
  // clock and stream control
  input wire logic i_clk,
  input wire logic i_stream_on,
  input wire logic i_flip,
  // recovered link side
  output logic o_present,
  output logic o_locked,
  output logic o_rec_pclk,
  output var dsoc_pkg::dsoc_vid_s o_vid
);
  logic [2:0] div;
  logic [3:0] lk;
  always_ff @(posedge i_clk) begin
    div <= i_stream_on ? div + 3'h1 : 3'h0;
    lk <= !i_stream_on ? 4'h0 : (lk == 4'hF) ? lk : lk + 4'h1;
  end
  assign o_present = i_stream_on;
  assign o_locked = lk == 4'hF;
  // clock stands still and data turns over once the stream stops
  assign o_rec_pclk = div[2];
  // flip inverts the control levels to make short control pulses
  assign o_vid = i_stream_on ? {24'hA2A2A2, 3'b101 ^ {3{i_flip}}} :
    {24'h5D5D5D, 3'b010};
endmodule
`default_nettype wire

/* File: test_deser_output_state_control.sv */
// testbench of the output state control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module test_deser_output_state_control;
  logic clk = 1'b0, rstn = 1'b0, power_down_bar_input = 1'b0, stream = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [26:0] vo, voe, strap = 27'h10;
  logic flip = 1'b0;
  logic pass, pass_oe, pclk, pclk_oe, lock, lock_oe, wreq, pres, lkd, rpclk, last;
  dsoc_pkg::dsoc_vid_s vid;
  wire logic [26:0] vpad = (vo & voe) | (strap & ~voe); // pulldowns except pulled-up straps
  int mismatches = 0, tests_run = 0, r1, r2;
  int half [7] = '{1, 2, 3, 4, 5, 6, 8};
  logic [23:0] mexp [4] = '{24'hA2A2A2, 24'hA3A3A3, 24'hA0A0A0, 24'hA0A0A0};
  localparam logic [26:0] ACT = {3'b101, 24'hA2A2A2};
  always #5 clk = ~clk;
  dsoc_link_model link (.i_clk(clk), .i_stream_on(stream), .o_present(pres), .o_locked(lkd),
    .i_flip(flip), .o_rec_pclk(rpclk), .o_vid(vid));
  dsoc_out_ctrl dut (.i_clk(clk), .i_rstn(rstn), .i_pdb(power_down_bar_input), .i_embedded_clk_present(pres),
    .i_cdr_locked(lkd), .i_rec_pclk(rpclk), .i_vid(vid), .i_vid_pad(vpad),
    .i_pass_pad(pass_oe ? pass : 1'b0), .o_vid_pad(vo), .o_vid_pad_oe(voe), .o_pass(pass),
    .o_pass_oe(pass_oe), .o_pclk(pclk), .o_pclk_oe(pclk_oe), .o_lock(lock), .o_lock_oe(lock_oe),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    if (k == 50) mismatches++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cfg(input logic [9:0] c);
    bus(1'b1, dsoc_pkg::ADDR_CONFIG, {22'h0, c});
    repeat (12) @(posedge clk);
  endtask
  task automatic hold_bit(input logic b);
    bus(1'b1, dsoc_pkg::ADDR_CONTROL, {31'h0, b});
    repeat (12) @(posedge clk);
  endtask
  task automatic pulse(input int n, output int seen);
    seen = 0;
    flip <= 1'b1;
    for (int k = 0; k < 48; k++) begin
      @(posedge clk);
      if (k == n - 1) flip <= 1'b0;
      if (vo[26:24] !== 3'b101) seen++;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("enables before power up", 27'h0, voe)
    power_down_bar_input <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("lock enable", 1'b1, lock_oe)
    `CHK("lock", 1'b0, lock)
    `CHK("idle low pads", {{27{1'b1}}, 27'h0}, {voe, vo})
    bus(1'b0, dsoc_pkg::ADDR_STATUS, 32'h0);
    `CHK("strap done", 2'b10, {q[dsoc_pkg::ST_STRAP_DONE], q[dsoc_pkg::ST_LOCK]})
    $display("test power up done");
    stream <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("lock and pass", 3'b111, {lock, pass, pclk_oe})
    `CHK("active pads", ACT, vo)
    bus(1'b0, 4'h2, 32'h0);
    `CHK("unmapped read", 32'h0, q)
    bus(1'b1, dsoc_pkg::ADDR_OVERRIDE, {24'h0, dsoc_pkg::OVERRIDE_ON});
    bus(1'b0, dsoc_pkg::ADDR_OVERRIDE, 32'h0);
    `CHK("override", 32'h1, q)
    for (int m = 0; m < 4; m++) begin
      cfg(10'(m << 6) | 10'h010);
      `CHK("mapped rgb", mexp[m], vo[23:0])
    end
    $display("test mapping done");
    cfg(10'h210);
    `CHK("held pads and lock", {1'b1, 27'h0}, {lock, vo})
    hold_bit(1'b1);
    `CHK("released pads", ACT, vo)
    hold_bit(1'b0);
    `CHK("manual hold", 27'h0, vo)
    hold_bit(1'b1);
    stream <= 1'b0;
    repeat (20) @(posedge clk);
    stream <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK("hold after lock fall", {1'b1, 27'h0}, {lock, vo})
    hold_bit(1'b0);
    hold_bit(1'b1);
    `CHK("release when locked", ACT, vo)
    $display("test hold done");
    cfg(10'h230);
    pulse(8, r1);
    `CHK("filtered one clock pulse", 0, r1)
    pulse(16, r1);
    `CHK("filtered two clock pulse", 0, r1)
    pulse(24, r1);
    `CHK("three clock pulse passes", 1'b1, r1 > 0)
    cfg(10'h210);
    pulse(8, r1);
    `CHK("unfiltered pulse", 1'b1, r1 > 0)
    $display("test filter done");
    stream <= 1'b0;
    for (int c = 1; c < 8; c++) begin
      cfg(10'(c << 1) | 10'h010);
      r1 = -1;
      r2 = -1;
      last = pclk;
      for (int k = 0; k < 40; k++) begin
        @(posedge clk);
        if (pclk === 1'b1 && last === 1'b0) begin
          if (r1 < 0) r1 = k;
          else if (r2 < 0) r2 = k;
        end
        last = pclk;
      end
      `CHK("oscillator period", 2 * half[c-1], r2 - r1)
      `CHK("osc lock and data", 28'h0, {lock, vo})
    end
    $display("test oscillator done");
    power_down_bar_input <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("power down float", 30'h0, {voe, lock_oe, pass_oe, pclk_oe})
    power_down_bar_input <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, dsoc_pkg::ADDR_OVERRIDE, 32'h0);
    `CHK("override after power down", 32'h0, q)
    $display("test power down done");
    conclude();
  end
endmodule
`default_nettype wire
